// [verilog/mph_pkg.sv]
// package: constants and types of the midi parameter message handler
package mph_pkg;
  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int AW = 4;
  localparam int DW = 16;
  localparam int PW = 14;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CHAN = 4'h1;
  localparam logic [3:0] REG_STEPS = 4'h2;
  localparam logic [3:0] REG_MMC = 4'h3;
  localparam logic [3:0] REG_MAPA = 4'h4;
  localparam logic [3:0] REG_CMAP = 4'h5;
  localparam logic [3:0] REG_PMAP = 4'h6;
  localparam logic [3:0] REG_PNUM = 4'h7;
  localparam logic [3:0] REG_PVAL = 4'h8;
  localparam logic [3:0] REG_RECALL = 4'h9;
  localparam logic [3:0] REG_STAT = 4'hA;
  localparam logic [3:0] REG_LASTN = 4'hB;
  localparam logic [3:0] REG_LASTV = 4'hC;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CHAN_RST = 16'h0000;
  localparam logic [15:0] STEPS_RST = 16'h0080;
  localparam logic [15:0] MMC_RST = 16'h137F;
  // control bit positions
  localparam int B_RXEN = 0;
  localparam int B_BANK = 1;
  localparam int B_CCA = 2;
  localparam int B_CCM = 3;
  localparam int B_NRPN = 4;
  localparam int B_PCRX = 5;
  localparam int B_ANY_CHANNEL_ACCEPT = 6;
  localparam int B_PCM = 7;
  localparam int B_ECHO = 8;
  localparam int B_PCTX = 9;
  localparam int B_WIDE = 10;
  // ---------------------------------------------------------------
  // midi message constants
  // ---------------------------------------------------------------
  localparam logic [3:0] ST_CC = 4'hB;
  localparam logic [3:0] ST_PC = 4'hC;
  localparam logic [3:0] ST_AT = 4'hD;
  localparam logic [7:0] SYS_FIRST = 8'hF0;
  localparam logic [7:0] RT_FIRST = 8'hF8;
  localparam logic [7:0] SX_RT = 8'h7F;
  localparam logic [7:0] SX_MCC = 8'h06;
  localparam logic [7:0] SX_END = 8'hF7;
  localparam logic [6:0] CC_BANK = 7'h00;
  localparam logic [6:0] CC_DE_M = 7'h06;
  localparam logic [6:0] CC_DE_L = 7'h26;
  localparam logic [6:0] CC_INC = 7'h60;
  localparam logic [6:0] CC_DEC = 7'h61;
  localparam logic [6:0] CC_NR_L = 7'h62;
  localparam logic [6:0] CC_NR_M = 7'h63;
  localparam logic [6:0] CC_LSB_OFS = 7'h20;
  localparam logic [6:0] CC_LSB_TOP = 7'h1F;
  localparam logic [6:0] CC_LAST = 7'h77;
  localparam logic [13:0] MULTI_SPAN = 14'h000F;
  localparam logic [13:0] FULL7 = 14'h007F;
  localparam logic [13:0] FULL14 = 14'h3FFF;
  localparam logic [14:0] BASE7 = 15'h0080;
  localparam logic [14:0] BASE14 = 15'h4000;
  localparam int MSG_MAX = 9;
  typedef enum {MPH_IDLE, MPH_SEND} mph_tx_t;
endpackage

// [verilog/mph_midi_param.sv]
// midi parameter message handler: parser, scaler and message builder
// Function
// RULE1: bank select sets bank; sent before program
// RULE2: single mode control change edits mapped parameter
// RULE3: multi mode adds channel to mapped parameter
// RULE4: received changes not echoed, still transmitted
// RULE5: single mode mapped change sends control change
// RULE6: multi mode channel is parameter offset, max 15
// RULE7: lowest controller number wins on transmit
// RULE8: controller plus 32 carries wide lsb
// RULE9: control change format and legal controller set
// RULE10: scaling quotient X, remainder Y, offset Z
// RULE11: receive scaling with zero and max clamp
// RULE12: transmit scaling with zero and full ends
// RULE13: nrpn reception edits one fixed parameter; here it edits the parameter numbered by controllers 62 and 63
// RULE14: nrpn transmit unless mapped control change
// RULE15: narrow parameters omit data entry lsb
// RULE16: nrpn order 62, 63, 06, 26
// RULE17: increment and decrement controllers ignored
// RULE18: program change channel match or any channel
// RULE19: multi mode channel selects recall bank
// RULE20: echo program change, recall mapped entry
// RULE21: recall sends lowest program number
// RULE22: triggers send machine control frame
// RULE23: disabled input discards all messages
`timescale 1ns/10ps
module mph_midi_param (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [mph_pkg::AW-1:0] addr_i,
  input wire logic [mph_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [mph_pkg::DW-1:0] rdata_o,
  // midi in byte stream
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  // midi out byte stream
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // transport trigger pins
  input wire logic user_key_assignment_i,
  input wire logic general_purpose_input_trigger_i,
  // parameter and recall results
  output logic param_wr_o,
  output logic [mph_pkg::PW-1:0] param_num_o,
  output logic [mph_pkg::PW-1:0] param_val_o,
  output logic recall_o,
  output logic [6:0] recall_entry_o,
  output logic [6:0] recall_bank_o
);
  import mph_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [15:0] ctrl_r, chan_r, steps_r, mmc_r;
  logic [6:0] mapa_r, bank_r, de_msb_r, cc_msb_r, echo_p_r, rc_ent_r;
  logic [13:0] host_pn_r, nrpn_num_r, pp_num_r, pp_val_r;
  logic [14:0] cmap_r [128];
  logic [7:0] pmap_r [128];
  logic [7:0] st_r, d1_r, echo_b_r;
  logic have1_r, uk_pend_r, gp_pend_r, rc_pend_r, ec_pend_r, pp_pend_r;
  logic [2:0] uk_q, gp_q;
  logic [7:0] msg_r [MSG_MAX];
  logic [7:0] msg_n [MSG_MAX];
  logic [3:0] len_r, idx_r, len_n;
  mph_tx_t state_r;
  logic [3:0] receive_channel_setting, transmit_channel_setting, ch;
  logic any_channel_accept, wide, mul, chm, rxv, two, ev_cc, ev_pc;
  logic [6:0] c, v;
  logic [14:0] ent, lo, stp, base, sx, sy, sz, pmax, q, e;
  logic [13:0] chofs, apn, ad, rx_p, tx_d, df;
  logic [6:0] dm, hc, rprog;
  logic [3:0] hch;
  logic apply, bank_set, pc_ok, hit, rhit, busy;
  logic take_uk, take_gp, take_rc, take_ec, take_pp;
  logic [31:0] prod;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // legal controller numbers for assignment
  function automatic logic cc_ok(input logic [6:0] n);
    cc_ok = (n >= 7'h01 && n <= 7'h05) || (n >= 7'h07 && n <= 7'h1F) ||
            (n >= 7'h21 && n <= 7'h25) || (n >= 7'h27 && n <= 7'h5F) ||
            (n >= 7'h66 && n <= CC_LAST); // RULE9
  endfunction

  // config fields
  assign receive_channel_setting = chan_r[3:0];
  assign transmit_channel_setting = chan_r[7:4];
  assign any_channel_accept = ctrl_r[B_ANY_CHANNEL_ACCEPT];
  assign wide = ctrl_r[B_WIDE];
  assign mul = ctrl_r[B_CCM];
  assign busy = (state_r == MPH_SEND);

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  // config writes; maps reset so no stale entry matches
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= CTRL_RST;
      chan_r <= CHAN_RST;
      steps_r <= STEPS_RST;
      mmc_r <= MMC_RST;
      mapa_r <= 7'h00;
      host_pn_r <= 14'h0000;
      for (int i = 0; i < 128; i++) begin
        cmap_r[i] <= 15'h0000;
        pmap_r[i] <= 8'h00;
      end
    end else if (wr_i) begin
      case (addr_i)
        REG_CTRL: ctrl_r <= wdata_i;
        REG_CHAN: chan_r <= wdata_i;
        REG_STEPS: steps_r <= wdata_i;
        REG_MMC: mmc_r <= wdata_i;
        REG_MAPA: mapa_r <= wdata_i[6:0];
        REG_CMAP: cmap_r[mapa_r] <= wdata_i[14:0];
        REG_PMAP: pmap_r[mapa_r] <= wdata_i[7:0];
        REG_PNUM: host_pn_r <= wdata_i[13:0];
        default: ;
      endcase
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        REG_CTRL: rdata_o <= ctrl_r;
        REG_CHAN: rdata_o <= chan_r;
        REG_STEPS: rdata_o <= steps_r;
        REG_MMC: rdata_o <= mmc_r;
        REG_MAPA: rdata_o <= {9'h000, mapa_r};
        REG_CMAP: rdata_o <= {1'b0, cmap_r[mapa_r]};
        REG_PMAP: rdata_o <= {8'h00, pmap_r[mapa_r]};
        REG_PNUM: rdata_o <= {2'h0, host_pn_r};
        REG_STAT: rdata_o <= {8'h00, busy, bank_r};
        REG_LASTN: rdata_o <= {2'h0, param_num_o};
        REG_LASTV: rdata_o <= {2'h0, param_val_o};
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // value scaling
  // ---------------------------------------------------------------
  // zero steps would divide by zero, so treat it as one
  always_comb begin
    stp = (steps_r[14:0] == 15'h0000) ? 15'h0001 : steps_r[14:0];
    base = wide ? BASE14 : BASE7;
    sx = base / stp; // RULE10
    if (sx == 15'h0000) begin
      sx = 15'h0001;
    end
    sy = base % stp;
    sz = (sy + 15'h0001) >> 1;
    pmax = stp - 15'h0001;
    q = ({1'b0, ad} - sz) / sx;
    if ({1'b0, ad} < sz) begin
      rx_p = 14'h0000; // RULE11
    end else if (q > pmax) begin
      rx_p = pmax[13:0];
    end else begin
      rx_p = q[13:0];
    end
    prod = 32'(sx) * 32'(pp_val_r) + 32'(sx >> 1) + 32'(sz);
    if (pp_val_r == 14'h0000) begin
      tx_d = 14'h0000; // RULE12
    end else if ({1'b0, pp_val_r} >= pmax) begin
      tx_d = wide ? FULL14 : FULL7;
    end else begin
      tx_d = prod[13:0];
    end
    dm = wide ? tx_d[13:7] : tx_d[6:0];
  end

  // ---------------------------------------------------------------
  // receive parser
  // ---------------------------------------------------------------
  assign rxv = rx_valid_i & ctrl_r[B_RXEN]; // RULE23
  assign two = (st_r[7:4] != ST_PC) && (st_r[7:4] != ST_AT);
  assign ev_cc = rxv && !rx_byte_i[7] && st_r[7:4] == ST_CC && have1_r;
  assign ev_pc = rxv && !rx_byte_i[7] && st_r[7:4] == ST_PC;
  assign ch = st_r[3:0];
  assign c = d1_r[6:0];
  assign v = rx_byte_i[6:0];
  assign chm = (ch == receive_channel_setting);
  assign ent = cmap_r[c];
  assign lo = cmap_r[c - CC_LSB_OFS];
  assign chofs = mul ? {10'h000, ch} : 14'h0000;

  // running status; real-time bytes pass without disturbing it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= 8'h00;
      d1_r <= 8'h00;
      have1_r <= 1'b0;
    end else if (rxv) begin
      if (rx_byte_i[7]) begin
        if (rx_byte_i < RT_FIRST) begin
          st_r <= (rx_byte_i < SYS_FIRST) ? rx_byte_i : 8'h00;
          have1_r <= 1'b0;
        end
      end else if (st_r[7] && two) begin
        have1_r <= !have1_r;
        d1_r <= rx_byte_i;
      end
    end
  end

  // control change decode
  always_comb begin
    apply = 1'b0;
    apn = 14'h0000;
    ad = 14'h0000;
    bank_set = 1'b0;
    if (ev_cc) begin
      if (c == CC_BANK) begin
        bank_set = ctrl_r[B_BANK] && !ctrl_r[B_PCM] && chm; // RULE1
      end else if (c == CC_INC || c == CC_DEC) begin
        apply = 1'b0; // RULE17
      end else if (ctrl_r[B_NRPN] && chm && (c == CC_DE_M || c == CC_DE_L)) begin
        apply = (c == CC_DE_M) ? !wide : wide; // RULE13
        apn = nrpn_num_r;
        ad = wide ? {de_msb_r, v} : {7'h00, v};
      end else if (ctrl_r[B_CCA] && cc_ok(c) && (mul || chm)) begin
        if (wide && c > CC_LSB_OFS && c <= CC_LSB_OFS + CC_LSB_TOP && !ent[14] && lo[14]) begin
          apply = 1'b1; // RULE8
          apn = lo[13:0] + chofs;
          ad = {cc_msb_r, v};
        end else begin
          apply = ent[14]; // RULE2 RULE3
          apn = ent[13:0] + chofs;
          ad = wide ? {v, 7'h00} : {7'h00, v};
        end
      end
    end
  end

  // bank, nrpn number and msb holding
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bank_r <= 7'h00;
      nrpn_num_r <= 14'h0000;
      de_msb_r <= 7'h00;
      cc_msb_r <= 7'h00;
    end else if (ev_cc) begin
      if (bank_set) begin
        bank_r <= v;
      end
      if (ctrl_r[B_NRPN] && chm && c == CC_NR_L) begin
        nrpn_num_r[6:0] <= v;
      end
      if (ctrl_r[B_NRPN] && chm && c == CC_NR_M) begin
        nrpn_num_r[13:7] <= v;
      end
      if (ctrl_r[B_NRPN] && chm && c == CC_DE_M) begin
        de_msb_r <= v;
      end
      if (ctrl_r[B_CCA] && c <= CC_LSB_TOP) begin
        cc_msb_r <= v;
      end
    end
  end

  // program change acceptance
  assign pc_ok = ev_pc && ctrl_r[B_PCRX] &&
                 (ctrl_r[B_PCM] || any_channel_accept || chm); // RULE18 RULE19

  // parameter and recall result pulses
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      param_wr_o <= 1'b0;
      param_num_o <= 14'h0000;
      param_val_o <= 14'h0000;
      recall_o <= 1'b0;
      recall_entry_o <= 7'h00;
      recall_bank_o <= 7'h00;
    end else begin
      param_wr_o <= apply;
      if (apply) begin
        param_num_o <= apn;
        param_val_o <= rx_p;
      end
      recall_o <= pc_ok && pmap_r[v][7]; // RULE20
      if (pc_ok) begin
        recall_entry_o <= pmap_r[v][6:0];
        recall_bank_o <= ctrl_r[B_PCM] ? {3'h0, ch} : bank_r; // RULE19
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit requests
  // ---------------------------------------------------------------
  // trigger pins: two-stage sync, third stage for the edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      uk_q <= 3'h0;
      gp_q <= 3'h0;
    end else begin
      uk_q <= {uk_q[1:0], user_key_assignment_i};
      gp_q <= {gp_q[1:0], general_purpose_input_trigger_i};
    end
  end

  // pending flags: a new request beats the clear of the one taken
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      uk_pend_r <= 1'b0;
      gp_pend_r <= 1'b0;
      rc_pend_r <= 1'b0;
      ec_pend_r <= 1'b0;
      pp_pend_r <= 1'b0;
      rc_ent_r <= 7'h00;
      echo_b_r <= 8'h00;
      echo_p_r <= 7'h00;
      pp_num_r <= 14'h0000;
      pp_val_r <= 14'h0000;
    end else begin
      uk_pend_r <= (uk_q[1] & ~uk_q[2]) | (uk_pend_r & ~take_uk);
      gp_pend_r <= (gp_q[1] & ~gp_q[2]) | (gp_pend_r & ~take_gp);
      rc_pend_r <= (wr_i && addr_i == REG_RECALL) | (rc_pend_r & ~take_rc);
      ec_pend_r <= (pc_ok && ctrl_r[B_ECHO]) | (ec_pend_r & ~take_ec);
      pp_pend_r <= apply | (wr_i && addr_i == REG_PVAL) | (pp_pend_r & ~take_pp); // RULE4
      if (wr_i && addr_i == REG_RECALL) begin
        rc_ent_r <= wdata_i[6:0];
      end
      if (pc_ok) begin
        echo_b_r <= {ST_PC, ch};
        echo_p_r <= v;
      end
      if (apply) begin
        pp_num_r <= apn;
        pp_val_r <= rx_p;
      end else if (wr_i && addr_i == REG_PVAL) begin
        pp_num_r <= host_pn_r;
        pp_val_r <= wdata_i[13:0];
      end
    end
  end

  // controller search; descending scan leaves the lowest match
  always_comb begin
    hit = 1'b0;
    hc = 7'h00;
    hch = 4'h0;
    e = 15'h0000;
    df = 14'h0000;
    for (int i = 127; i >= 1; i--) begin
      e = cmap_r[i];
      df = pp_num_r - e[13:0];
      if (cc_ok(7'(i)) && e[14] &&
          (mul ? (pp_num_r >= e[13:0] && df <= MULTI_SPAN) : e[13:0] == pp_num_r)) begin
        hit = 1'b1; // RULE7
        hc = 7'(i);
        hch = mul ? df[3:0] : transmit_channel_setting; // RULE6
      end
    end
  end

  // program search for a recalled entry, lowest number wins
  always_comb begin
    rhit = 1'b0;
    rprog = 7'h00;
    for (int i = 127; i >= 0; i--) begin
      if (pmap_r[i] == {1'b1, rc_ent_r}) begin
        rhit = 1'b1; // RULE21
        rprog = 7'(i);
      end
    end
  end

  // message builder; fixed priority transport, recall, echo, parameter
  always_comb begin
    for (int i = 0; i < MSG_MAX; i++) begin
      msg_n[i] = 8'h00;
    end
    len_n = 4'h0;
    take_uk = 1'b0;
    take_gp = 1'b0;
    take_rc = 1'b0;
    take_ec = 1'b0;
    take_pp = 1'b0;
    if (state_r == MPH_IDLE) begin
      if (uk_pend_r || gp_pend_r) begin
        take_uk = uk_pend_r;
        take_gp = !uk_pend_r;
        msg_n[0] = SYS_FIRST; // RULE22
        msg_n[1] = SX_RT;
        msg_n[2] = {1'b0, mmc_r[6:0]};
        msg_n[3] = SX_MCC;
        msg_n[4] = {5'h00, uk_pend_r ? mmc_r[10:8] : mmc_r[14:12]};
        msg_n[5] = SX_END;
        len_n = 4'h6;
      end else if (rc_pend_r) begin
        take_rc = 1'b1;
        if (rhit && ctrl_r[B_PCTX]) begin
          if (ctrl_r[B_BANK] && !ctrl_r[B_PCM]) begin
            msg_n[0] = {ST_CC, transmit_channel_setting}; // RULE1
            msg_n[1] = {1'b0, CC_BANK};
            msg_n[2] = {1'b0, bank_r};
            len_n = 4'h3;
          end
          msg_n[len_n] = {ST_PC, ctrl_r[B_PCM] ? 4'h0 : transmit_channel_setting}; // RULE21
          msg_n[len_n + 4'h1] = {1'b0, rprog};
          len_n = len_n + 4'h2;
        end
      end else if (ec_pend_r) begin
        take_ec = 1'b1;
        msg_n[0] = echo_b_r; // RULE20
        msg_n[1] = {1'b0, echo_p_r};
        len_n = 4'h2;
      end else if (pp_pend_r) begin
        take_pp = 1'b1;
        if (ctrl_r[B_CCA] && hit) begin
          msg_n[0] = {ST_CC, hch}; // RULE5 RULE14
          msg_n[1] = {1'b0, hc};
          msg_n[2] = {1'b0, dm};
          len_n = 4'h3;
          if (wide && hc <= CC_LSB_TOP) begin
            msg_n[3] = {1'b0, hc + CC_LSB_OFS}; // RULE8
            msg_n[4] = {1'b0, tx_d[6:0]};
            len_n = 4'h5;
          end
        end else if (ctrl_r[B_NRPN]) begin
          msg_n[0] = {ST_CC, transmit_channel_setting}; // RULE14 RULE16
          msg_n[1] = {1'b0, CC_NR_L};
          msg_n[2] = {1'b0, pp_num_r[6:0]};
          msg_n[3] = {1'b0, CC_NR_M};
          msg_n[4] = {1'b0, pp_num_r[13:7]};
          msg_n[5] = {1'b0, CC_DE_M};
          msg_n[6] = {1'b0, dm};
          len_n = 4'h7;
          if (wide) begin
            msg_n[7] = {1'b0, CC_DE_L}; // RULE15
            msg_n[8] = {1'b0, tx_d[6:0]};
            len_n = 4'h9;
          end
        end
      end
    end
  end

  // byte sender with ready back-pressure
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= MPH_IDLE;
      tx_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
      len_r <= 4'h0;
      idx_r <= 4'h0;
      for (int i = 0; i < MSG_MAX; i++) begin
        msg_r[i] <= 8'h00;
      end
    end else begin
      case (state_r)
        MPH_IDLE: begin
          if (len_n != 4'h0) begin
            msg_r <= msg_n;
            len_r <= len_n;
            idx_r <= 4'h1;
            tx_byte_o <= msg_n[0];
            tx_valid_o <= 1'b1;
            state_r <= MPH_SEND;
          end
        end
        MPH_SEND: begin
          if (tx_ready_i) begin
            if (idx_r == len_r) begin
              tx_valid_o <= 1'b0;
              state_r <= MPH_IDLE;
            end else begin
              tx_byte_o <= msg_r[idx_r];
              idx_r <= idx_r + 4'h1;
            end
          end
        end
        default: state_r <= MPH_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_rule23;
    param_wr_o |-> $past(ctrl_r[B_RXEN]);
  endproperty
  a_rule23: assert property (p_rule23) else $error("change with input off"); // RULE23
  property p_rule17;
    ev_cc && (c == CC_INC || c == CC_DEC) |=> !param_wr_o;
  endproperty
  a_rule17: assert property (p_rule17) else $error("inc or dec acted on"); // RULE17
  property p_rule11;
    apply && ({1'b0, ad} < sz) |=> param_val_o == 14'h0000;
  endproperty
  a_rule11: assert property (p_rule11) else $error("negative data not zero"); // RULE11
  property p_rule11_max;
    param_wr_o |-> {1'b0, param_val_o} <= $past(pmax);
  endproperty
  a_rule11_max: assert property (p_rule11_max) else $error("value above max"); // RULE11
  property p_rule1;
    bank_set |=> bank_r == $past(rx_byte_i[6:0]);
  endproperty
  a_rule1: assert property (p_rule1) else $error("bank not taken"); // RULE1
  property p_rule18;
    ev_pc && !ctrl_r[B_PCM] && !any_channel_accept && !chm |=> !recall_o;
  endproperty
  a_rule18: assert property (p_rule18) else $error("foreign channel recall"); // RULE18
  property p_rule22;
    tx_valid_o && tx_ready_i && tx_byte_o == SYS_FIRST |=> tx_valid_o && tx_byte_o == SX_RT;
  endproperty
  a_rule22: assert property (p_rule22) else $error("bad transport frame"); // RULE22
  property p_rule16;
    take_pp && !(ctrl_r[B_CCA] && hit) && ctrl_r[B_NRPN] |=> msg_r[1] == {1'b0, CC_NR_L} &&
      msg_r[3] == {1'b0, CC_NR_M} && msg_r[5] == {1'b0, CC_DE_M} && len_r == (wide ? 4'h9 : 4'h7);
  endproperty
  a_rule16: assert property (p_rule16) else $error("bad nrpn sequence"); // RULE16
  c_mmc: cover property (tx_valid_o && tx_byte_o == SYS_FIRST);
  c_recall: cover property (recall_o);
  c_param: cover property (param_wr_o ##1 tx_valid_o);
  c_nrpn: cover property (take_pp && ctrl_r[B_NRPN] && wide);
endmodule

// [tb/mph_midi_peer.sv]
// midi out sink model with a stalling ready
`timescale 1ns/10ps
module mph_midi_peer (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // byte stream from the block
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic [7:0] got[$];
  logic [1:0] ph_r;
  // stall one cycle in four so held bytes get exercised
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_r <= 2'h0;
      tx_ready_o <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      tx_ready_o <= (ph_r != 2'h2);
    end
  end
  // a byte counts only on a valid and ready edge
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) got.push_back(tx_byte_i);
  end
endmodule

// [tb/mph_midi_param_tb_top.sv]
// self-checking bench of the midi parameter message handler
`timescale 1ns/10ps
module mph_midi_param_tb_top;
  import mph_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rx_byte_i = 8'h00;
  logic rx_valid_i = 1'b0;
  logic key_i = 1'b0;
  logic gpi_i = 1'b0;
  logic [15:0] rdata_o;
  logic [7:0] tx_byte_o;
  logic tx_valid_o, tx_ready_i, param_wr_o, recall_o;
  logic [13:0] param_num_o, param_val_o;
  logic [6:0] recall_entry_o, recall_bank_o;
  int err_total = 0;
  int n_compared = 0;
  int n_pw = 0;
  int n_rc = 0;
  logic [7:0] exp_q[$];
  logic [15:0] mm[4] = '{16'h017F, 16'h3005, 16'h0400, 16'h507E};
  always #2.5 clk_i = ~clk_i;
  mph_midi_param u_mph_midi_param (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_byte_i(rx_byte_i),
    .rx_valid_i(rx_valid_i), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .user_key_assignment_i(key_i),
    .general_purpose_input_trigger_i(gpi_i), .param_wr_o(param_wr_o),
    .param_num_o(param_num_o), .param_val_o(param_val_o), .recall_o(recall_o),
    .recall_entry_o(recall_entry_o), .recall_bank_o(recall_bank_o));
  mph_midi_peer u_mph_midi_peer (.clk_i(clk_i), .nrst_i(nrst_i), .tx_byte_i(tx_byte_o),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
  // count result pulses at the edge that sees them
  always @(posedge clk_i) begin
    n_pw += int'(param_wr_o === 1'b1);
    n_rc += int'(recall_o === 1'b1);
  end
  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // idle byte lines show the inverse so stale data never matches
  task automatic rx(input logic [7:0] b);
    @(posedge clk_i);
    rx_byte_i <= b;
    rx_valid_i <= 1'b1;
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    rx_byte_i <= ~b;
  endtask
  task automatic chk_tx();
    int k;
    k = 0;
    while (u_mph_midi_peer.got.size() < exp_q.size() && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    repeat (30) @(posedge clk_i);
    chk(16'(u_mph_midi_peer.got.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) chk({8'h00, u_mph_midi_peer.got[i]}, {8'h00, exp_q[i]});
    u_mph_midi_peer.got.delete();
    exp_q.delete();
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(REG_CTRL, CTRL_RST);
    rd(REG_STEPS, STEPS_RST);
    rd(REG_MMC, MMC_RST);
    rd(4'hF, 16'h0000);
    $display("test regs done");
    wr(REG_MAPA, 16'h0007);
    wr(REG_CMAP, 16'h4005);
    wr(REG_MAPA, 16'h0060);
    wr(REG_CMAP, 16'h4006);
    wr(REG_CHAN, 16'h0010);
    wr(REG_CTRL, 16'h0004);
    rx(8'hB0); rx(8'h07); rx(8'h40);
    repeat (4) @(posedge clk_i);
    chk(16'(n_pw), 16'h0000);
    chk_tx();
    wr(REG_CTRL, 16'h0005);
    rx(8'hB3); rx(8'h07); rx(8'h11);
    rx(8'hB0); rx(8'h60); rx(8'h11);
    rx(8'h07); rx(8'h40);
    repeat (4) @(posedge clk_i);
    chk(16'(n_pw), 16'h0001);
    chk(16'(param_num_o), 16'h0005);
    chk(16'(param_val_o), 16'h0040);
    exp_q = {8'hB1, 8'h07, 8'h40};
    chk_tx();
    $display("test cc done");
    wr(REG_MAPA, 16'h0005);
    wr(REG_PMAP, 16'h0089);
    wr(REG_CTRL, 16'h0323);
    rx(8'hB0); rx(8'h00); rx(8'h02);
    rx(8'hC0); rx(8'h05);
    repeat (4) @(posedge clk_i);
    chk(16'(n_rc), 16'h0001);
    chk(16'(recall_entry_o), 16'h0009);
    chk(16'(recall_bank_o), 16'h0002);
    // a received program change only echoes; the host recall transmits
    wr(REG_RECALL, 16'h0009);
    exp_q = {8'hC0, 8'h05, 8'hB1, 8'h00, 8'h02, 8'hC1, 8'h05};
    chk_tx();
    $display("test pc done");
    wr(REG_CTRL, 16'h0005);
    wr(REG_STEPS, 16'h0003);
    rx(8'hB0); rx(8'h07); rx(8'h7F);
    repeat (4) @(posedge clk_i);
    chk(16'(param_val_o), 16'h0002);
    exp_q = {8'hB1, 8'h07, 8'h7F};
    chk_tx();
    $display("test scale done");
    // controller 3 also maps param 5, so it must win on transmit
    wr(REG_MAPA, 16'h0003);
    wr(REG_CMAP, 16'h4005);
    wr(REG_CTRL, 16'h000D);
    rx(8'hB3); rx(8'h07); rx(8'h7F);
    repeat (4) @(posedge clk_i);
    chk(16'(param_num_o), 16'h0008);
    exp_q = {8'hB3, 8'h03, 8'h7F};
    chk_tx();
    $display("test multi done");
    wr(REG_CTRL, 16'h0011);
    rx(8'hB0); rx(8'h62); rx(8'h05);
    rx(8'h63); rx(8'h00); rx(8'h06); rx(8'h40);
    repeat (4) @(posedge clk_i);
    chk(16'(param_num_o), 16'h0005);
    chk(16'(param_val_o), 16'h0001);
    exp_q = {8'hB1, 8'h62, 8'h05, 8'h63, 8'h00, 8'h06, 8'h40};
    chk_tx();
    $display("test nrpn done");
    // commands 1, 3, 4 and 5 from both trigger pins
    foreach (mm[i]) begin
      wr(REG_MMC, mm[i]);
      @(posedge clk_i);
      key_i <= ~i[0];
      gpi_i <= i[0];
      exp_q = {8'hF0, 8'h7F, mm[i][7:0], 8'h06, 8'h00, 8'hF7};
      exp_q[4] = {5'h00, (i[0] ? mm[i][14:12] : mm[i][10:8])};
      chk_tx();
      key_i <= 1'b0;
      gpi_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
    $display("test mmc done");
    report_and_stop();
  end
endmodule
